/* link_ctrl_pkg.sv */
// constants for the camera link local control and status register bank
//
// What this block does
// [R1] Bits 15-14 select the link timeout: 00 gives 1023 link clocks (reset), 01 gives 64, 10 gives 128, 11 gives 64.
// [R2] Bits 13-12 always read zero and writes to them do nothing.
// [R3] Bits 6 and 4 always read zero and writes to them do nothing.
// [R4] Bits 11-8 show a fixed four-bit revision code and ignore writes.
// [R5] Bit 7 shows the cable detect pin, 0 when a cable is present, and ignores writes.
// [R6] Bit 5 shows the remote power sense pin, 1 when the remote is powered, and ignores writes.
// [R7] Bit 3 gates the interface clock with inverted sense: 0 runs it (reset), 1 stops it.
// [R8] Bit 2 switches the cable clock: 0 off (reset), 1 on.
// [R9] Bit 1 switches power to the remote: 0 off (reset), 1 on.
// [R10] Bit 0 set disables the link watchdog; at 0 (reset) the watchdog enforces the timeout.
// [R11] The upper reserved control register is not built: writes do nothing, reads give zero.
// [R12] With the watchdog on, a link cycle that outlasts the selected timeout raises the timeout flag.
// [R13] The host uses only 16-bit word accesses on the link registers, never byte accesses.
// [R14] Timeout option and the four control bits keep and read back their last written value.

package link_ctrl_pkg;

  // register indices as printed; byte address is four times the index
  localparam logic [15:0] LOCAL_CTRL_IDX     = 16'h1000;
  localparam logic [15:0] LOCAL_UPPER_IDX    = 16'h1002;
  localparam logic [15:0] EVT_STATUS_IDX     = 16'h1010;
  localparam logic [15:0] EVT_CLEAR_IDX      = 16'h1011;
  localparam logic [15:0] EVT_ENABLE_IDX     = 16'h1012;
  localparam logic [15:0] LINK_STATE_IDX     = 16'h1013;
  localparam int          ADR_W              = 16;
  localparam int          DAT_W              = 32;
  localparam int          IDX_W              = ADR_W - 2;

  // local control word field positions
  localparam int TO_HI      = 15;
  localparam int TO_LO      = 14;
  localparam int REV_HI     = 11;
  localparam int REV_LO     = 8;
  localparam int CABLE_BIT  = 7;
  localparam int REMOTE_BIT = 5;
  localparam int IFCLK_BIT  = 3;
  localparam int CCLK_BIT   = 2;
  localparam int POWER_BIT  = 1;
  localparam int WDOG_BIT   = 0;

  // reset values
  localparam logic [1:0] TO_RST    = 2'h0;
  localparam logic [3:0] CTRL_RST  = 4'h0;
  localparam logic [2:0] EVT_RST   = 3'h0;

  // timeout lengths in link clock cycles
  localparam int         CNT_W     = 10;
  localparam logic [CNT_W-1:0] TO_LEN_00 = 10'd1023;
  localparam logic [CNT_W-1:0] TO_LEN_01 = 10'd64;
  localparam logic [CNT_W-1:0] TO_LEN_10 = 10'd128;
  localparam logic [CNT_W-1:0] TO_LEN_11 = 10'd64;

  // event bits, shared by status, clear and enable
  localparam int EVT_TIMEOUT = 0;
  localparam int EVT_CABLE   = 1;
  localparam int EVT_REMOTE  = 2;
  localparam int EVT_W       = 3;

  // link state register bits
  localparam int ST_BUSY     = 0;
  localparam int ST_EXPIRED  = 1;

  // synchroniser stages
  localparam int SYNC_STAGES = 2;

endpackage : link_ctrl_pkg

/* pin_sync.sv */
// two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/100ps

module pin_sync #(
  parameter int W = 1
) (
  // clock and control
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         ce_i,
  // pins
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // first stage is read by the second stage only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      sync_r <= '0;
    end else if (ce_i) begin
      meta_r <= async_i;
      sync_r <= meta_r;
    end
  end

  assign sync_o = sync_r;

endmodule : pin_sync

/* link_watchdog.sv */
// link cycle watchdog counting link clock edges
`timescale 1ns/100ps

module link_watchdog #(
  parameter int CW = 10
) (
  // clock and control
  input  wire logic          clk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  // link side
  input  wire logic          tick_i,
  input  wire logic          active_i,
  input  wire logic          enable_i,
  input  wire logic [CW-1:0] limit_i,
  // result
  output logic               expire_o,
  output logic               expired_o
);

  logic [CW-1:0] count_r;
  logic          expired_r;
  wire           at_limit = (count_r == limit_i);
  wire           fire     = active_i && enable_i && tick_i && at_limit && !expired_r;

  // counter restarts with every new cycle; fires once per cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r   <= '0;
      expired_r <= 1'b0;
    end else if (ce_i) begin
      if (!active_i) begin
        count_r   <= '0;
        expired_r <= 1'b0;
      end else if (tick_i && !at_limit) begin
        count_r   <= count_r + 1'b1;
      end
      if (fire) begin
        expired_r <= 1'b1;
      end
    end
  end

  assign expire_o  = fire;
  assign expired_o = expired_r;

endmodule : link_watchdog

/* link_local_ctrl.sv */
// camera link local control and status register bank on a wishbone slave
`timescale 1ns/100ps

module link_local_ctrl
  import link_ctrl_pkg::*;
#(
  // arbitrary revision code
  parameter logic [3:0] REVISION = 4'h1
) (
  // clock, reset, enable
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  // wishbone slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [ADR_W-1:0] adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [DAT_W-1:0] dat_i,
  output logic      [DAT_W-1:0] dat_o,
  output logic                  ack_o,
  // pins from the cable
  input  wire logic             link_clk_i,
  input  wire logic             cable_detect_pin_i,
  input  wire logic             remote_power_sense_pin_i,
  // link engine, same clock
  input  wire logic             link_cycle_active_i,
  // control outputs
  output logic                  interface_clk_en_o,
  output logic                  cable_clock_on_o,
  output logic                  remote_power_on_o,
  output logic                  watchdog_disable_o,
  output logic      [CNT_W-1:0] timeout_len_o,
  output logic                  timeout_o,
  // interrupt
  output logic                  irq_o
);

  // ------------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------------
  logic [2:0] pins_sync;
  wire        link_clk_s;
  wire        cable_detect_s;
  wire        remote_power_s;

  pin_sync #(
    .W (3)
  ) u_pin_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i ({link_clk_i, cable_detect_pin_i, remote_power_sense_pin_i}),
    .sync_o  (pins_sync)
  );

  assign link_clk_s     = pins_sync[2];
  assign cable_detect_s = pins_sync[1];
  assign remote_power_s = pins_sync[0];

  // ------------------------------------------------------------------
  // edge finding on synchronised levels
  // ------------------------------------------------------------------
  logic link_clk_d_r;
  logic cable_detect_d_r;
  logic remote_power_d_r;
  logic [2:0] edges_valid_r;

  // valid only once the synchroniser and the delay flop both hold real pin levels
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_clk_d_r     <= 1'b0;
      cable_detect_d_r <= 1'b0;
      remote_power_d_r <= 1'b0;
      edges_valid_r    <= 3'h0;
    end else if (ce_i) begin
      link_clk_d_r     <= link_clk_s;
      cable_detect_d_r <= cable_detect_s;
      remote_power_d_r <= remote_power_s;
      edges_valid_r    <= {edges_valid_r[1:0], 1'b1};
    end
  end

  // first sample after reset is not a change, so no false event
  wire link_tick      = link_clk_s && !link_clk_d_r;
  wire cable_changed  = edges_valid_r[2] && (cable_detect_s != cable_detect_d_r);
  wire remote_changed = edges_valid_r[2] && (remote_power_s != remote_power_d_r);

  // ------------------------------------------------------------------
  // bus decode
  // ------------------------------------------------------------------
  wire [IDX_W-1:0] idx       = adr_i[ADR_W-1:2];
  wire             req       = cyc_i && stb_i;
  logic            ack_r;
  wire             wr_commit = req && we_i && ack_r;

  wire hit_ctrl   = (idx == LOCAL_CTRL_IDX[IDX_W-1:0]);
  wire hit_upper  = (idx == LOCAL_UPPER_IDX[IDX_W-1:0]);
  wire hit_status = (idx == EVT_STATUS_IDX[IDX_W-1:0]);
  wire hit_clear  = (idx == EVT_CLEAR_IDX[IDX_W-1:0]);
  wire hit_enable = (idx == EVT_ENABLE_IDX[IDX_W-1:0]);
  wire hit_state  = (idx == LINK_STATE_IDX[IDX_W-1:0]);

  // lane strobes: the host writes whole 16-bit words, but a stray
  // single byte still only touches its own lane
  // [R13] lane by lane
  wire lane_lo = sel_i[0];
  wire lane_hi = sel_i[1];

  wire wr_ctrl_lo = wr_commit && hit_ctrl && lane_lo;
  wire wr_ctrl_hi = wr_commit && hit_ctrl && lane_hi;
  wire wr_clear   = wr_commit && hit_clear && lane_lo;
  wire wr_enable  = wr_commit && hit_enable && lane_lo;

  // ------------------------------------------------------------------
  // stored control fields
  // ------------------------------------------------------------------
  logic [1:0] timeout_sel_r;
  logic [1:0] timeout_sel_nxt;
  logic [3:0] ctrl_r;
  logic [3:0] ctrl_nxt;

  // [R14] keep written fields
  assign timeout_sel_nxt = wr_ctrl_hi ? dat_i[TO_HI:TO_LO] : timeout_sel_r;
  assign ctrl_nxt        = wr_ctrl_lo ? dat_i[IFCLK_BIT:WDOG_BIT] : ctrl_r;

  // [R1] reset option 00
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_sel_r <= TO_RST;
      ctrl_r        <= CTRL_RST;
    end else if (ce_i) begin
      timeout_sel_r <= timeout_sel_nxt;
      ctrl_r        <= ctrl_nxt;
    end
  end

  // ------------------------------------------------------------------
  // control outputs
  // ------------------------------------------------------------------
  // [R7] inverted clock gate
  assign interface_clk_en_o = !ctrl_r[IFCLK_BIT];
  // [R8] cable clock switch
  assign cable_clock_on_o   = ctrl_r[CCLK_BIT];
  // [R9] remote power switch
  assign remote_power_on_o  = ctrl_r[POWER_BIT];
  // [R10] watchdog disable bit
  assign watchdog_disable_o = ctrl_r[WDOG_BIT];

  // [R1] option to length
  logic [CNT_W-1:0] timeout_len;
  always_comb begin
    unique case (timeout_sel_r)
      2'h0:    timeout_len = TO_LEN_00;
      2'h1:    timeout_len = TO_LEN_01;
      2'h2:    timeout_len = TO_LEN_10;
      2'h3:    timeout_len = TO_LEN_11;
    endcase
  end

  assign timeout_len_o = timeout_len;

  // ------------------------------------------------------------------
  // link watchdog
  // ------------------------------------------------------------------
  wire wdog_enable = !ctrl_r[WDOG_BIT];
  wire wdog_expire;
  wire wdog_expired;

  // [R12] flag overlong cycles
  link_watchdog #(
    .CW (CNT_W)
  ) u_link_watchdog (
    .clk_i     (clk_i),
    .rst_i     (rst_i),
    .ce_i      (ce_i),
    .tick_i    (link_tick),
    .active_i  (link_cycle_active_i),
    .enable_i  (wdog_enable),
    .limit_i   (timeout_len),
    .expire_o  (wdog_expire),
    .expired_o (wdog_expired)
  );

  // pulse registered so timeout_o is driven from a clean flop output
  logic timeout_r;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      timeout_r <= 1'b0;
    end else if (ce_i) begin
      timeout_r <= wdog_expire;
    end
  end

  assign timeout_o = timeout_r;

  // ------------------------------------------------------------------
  // events and interrupt
  // ------------------------------------------------------------------
  logic [EVT_W-1:0] evt_status_r;
  logic [EVT_W-1:0] evt_status_nxt;
  logic [EVT_W-1:0] evt_enable_r;
  logic [EVT_W-1:0] evt_enable_nxt;
  logic [EVT_W-1:0] evt_set;
  logic [EVT_W-1:0] evt_clr;

  always_comb begin
    evt_set              = '0;
    evt_set[EVT_TIMEOUT] = wdog_expire;
    evt_set[EVT_CABLE]   = cable_changed;
    evt_set[EVT_REMOTE]  = remote_changed;
  end

  assign evt_clr        = wr_clear ? dat_i[EVT_W-1:0] : '0;
  // set wins over a clear in the same cycle
  assign evt_status_nxt = (evt_status_r & ~evt_clr) | evt_set;
  assign evt_enable_nxt = wr_enable ? dat_i[EVT_W-1:0] : evt_enable_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      evt_status_r <= EVT_RST;
      evt_enable_r <= EVT_RST;
    end else if (ce_i) begin
      evt_status_r <= evt_status_nxt;
      evt_enable_r <= evt_enable_nxt;
    end
  end

  assign irq_o = |(evt_status_r & evt_enable_r);

  // ------------------------------------------------------------------
  // read data
  // ------------------------------------------------------------------
  logic [15:0] local_word;
  always_comb begin
    local_word                   = 16'h0000;
    // [R1] option reads back
    local_word[TO_HI:TO_LO]      = timeout_sel_r;
    // [R4] fixed revision
    local_word[REV_HI:REV_LO]    = REVISION;
    // [R5] cable detect level
    local_word[CABLE_BIT]        = cable_detect_s;
    // [R6] remote power level
    local_word[REMOTE_BIT]       = remote_power_s;
    local_word[IFCLK_BIT:WDOG_BIT] = ctrl_r;
    // [R2] bits 13-12 left zero
    // [R3] bits 6 and 4 left zero
  end

  wire [DAT_W-1:0] rd_ctrl   = {16'h0000, local_word};
  // [R11] upper register reads zero
  wire [DAT_W-1:0] rd_upper  = 32'h0000_0000;
  wire [DAT_W-1:0] rd_status = {{(DAT_W-EVT_W){1'b0}}, evt_status_r};
  wire [DAT_W-1:0] rd_enable = {{(DAT_W-EVT_W){1'b0}}, evt_enable_r};
  wire [DAT_W-1:0] rd_state  = {30'h0000_0000, wdog_expired, link_cycle_active_i};

  // clear register is write-only; unmapped reads give zero
  wire [DAT_W-1:0] rd_mux =
    hit_ctrl   ? rd_ctrl   :
    hit_upper  ? rd_upper  :
    hit_status ? rd_status :
    hit_enable ? rd_enable :
    hit_state  ? rd_state  : 32'h0000_0000;

  // ------------------------------------------------------------------
  // handshake: ack one cycle after the request, dropped the next
  // ------------------------------------------------------------------
  logic [DAT_W-1:0] dat_r;
  wire              ack_nxt = req && !ack_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      dat_r <= '0;
    end else if (ce_i) begin
      ack_r <= ack_nxt;
      if (ack_nxt && !we_i) begin
        dat_r <= rd_mux;
      end
    end
  end

  // ack also needs the request still present, so an abort drops it
  assign ack_o = ack_r && req;
  assign dat_o = dat_r;

endmodule : link_local_ctrl

/* remote_cam_model.sv */
// remote camera model at the far end of the link cable
`timescale 1ns/100ps

module remote_cam_model (
  // from the bench and the host side
  input  wire logic plugged_i,
  input  wire logic run_i,
  input  wire logic cable_clock_on_i,
  input  wire logic remote_power_on_i,
  // cable pins
  output logic      link_clk_o,
  output logic      cable_detect_pin_o,
  output logic      remote_power_sense_pin_o
);
  // clock rests low between frames, phase unrelated to the host clock
  initial link_clk_o = 1'b0;
  always begin
    #200;
    link_clk_o = (run_i && cable_clock_on_i) ? ~link_clk_o : 1'b0;
  end
  assign cable_detect_pin_o = !plugged_i;
  // sense high only if powered and plugged
  assign remote_power_sense_pin_o = plugged_i && remote_power_on_i;
endmodule : remote_cam_model

/* link_local_ctrl_properties.sv */
// concurrent checks on the local control register bank ports
`timescale 1ns/100ps

module link_local_ctrl_properties
  import link_ctrl_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1
) (
  // watched ports
  input wire logic             clk_i,
  input wire logic             rst_i,
  input wire logic             ce_i,
  input wire logic             cyc_i,
  input wire logic             stb_i,
  input wire logic             we_i,
  input wire logic [ADR_W-1:0] adr_i,
  input wire logic [3:0]       sel_i,
  input wire logic [DAT_W-1:0] dat_i,
  input wire logic [DAT_W-1:0] dat_o,
  input wire logic             ack_o,
  input wire logic             interface_clk_en_o,
  input wire logic             cable_clock_on_o,
  input wire logic             remote_power_on_o,
  input wire logic             watchdog_disable_o,
  input wire logic [CNT_W-1:0] timeout_len_o,
  input wire logic             timeout_o,
  input wire logic             irq_o
);
  wire       ctrl_hit = adr_i[15:2] == LOCAL_CTRL_IDX[13:0];
  wire       wr_ctrl  = ack_o && we_i && ctrl_hit;
  wire [3:0] ctl_bits = {!interface_clk_en_o, cable_clock_on_o, remote_power_on_o,
                         watchdog_disable_o};

  function automatic logic [CNT_W-1:0] to_len(input logic [1:0] opt);
    return opt == 2'h0 ? 10'd1023 : (opt == 2'h2 ? 10'd128 : 10'd64);
  endfunction : to_len

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_ack_answer: assert property ($rose(cyc_i && stb_i) && ce_i |=> ack_o)
    else $error("ack missing after request");
  chk_reset_state: assert property ($fell(rst_i) |-> ctl_bits == 4'h0
    && timeout_len_o == 10'd1023) else $error("wrong state after reset");
  chk_ctrl_write: assert property (wr_ctrl && sel_i[0] |=>
    ctl_bits == $past(dat_i[3:0])) else $error("control bits not stored");
  chk_len_write: assert property (wr_ctrl && sel_i[1] |=>
    timeout_len_o == to_len($past(dat_i[15:14]))) else $error("timeout length wrong");
  chk_ctrl_hold: assert property (!(ack_o && we_i) |=>
    $stable({ctl_bits, timeout_len_o})) else $error("control changed without write");
  chk_read_fixed: assert property (ack_o && !we_i && ctrl_hit |-> dat_o[13:12] == 2'h0
    && dat_o[6] == 1'b0 && dat_o[4] == 1'b0 && dat_o[11:8] == REVISION
    && dat_o[3:0] == ctl_bits) else $error("fixed or control field read wrong");
  chk_reserved_zero: assert property (ack_o && !we_i
    && adr_i[15:2] == LOCAL_UPPER_IDX[13:0] |-> dat_o == '0) else $error("reserved not zero");
  chk_timeout_pulse: assert property (timeout_o |=> !timeout_o)
    else $error("timeout longer than one cycle");
  chk_wdog_quiet: assert property (watchdog_disable_o && $past(watchdog_disable_o, 4)
    |-> !timeout_o) else $error("timeout while watchdog disabled");

  cov_ctrl_write: cover property (wr_ctrl);
  cov_timeout: cover property (timeout_o);
  cov_irq: cover property ($rose(irq_o));
endmodule : link_local_ctrl_properties

bind link_local_ctrl link_local_ctrl_properties #(.REVISION(REVISION)) props (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
  .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
  .interface_clk_en_o(interface_clk_en_o), .cable_clock_on_o(cable_clock_on_o),
  .remote_power_on_o(remote_power_on_o), .watchdog_disable_o(watchdog_disable_o),
  .timeout_len_o(timeout_len_o), .timeout_o(timeout_o), .irq_o(irq_o));

/* camera_link_local_control_status_tb.sv */
// self-checking bench for the local control register bank
`timescale 1ns/100ps

module camera_link_local_control_status_tb;
  import link_ctrl_pkg::*;
  // arbitrary revision code
  localparam logic [3:0] REV = 4'h5;
  logic             clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, act = 0, plug = 1;
  logic [15:0]      adr = '0;
  logic [31:0]      wdat = '0, rd;
  logic [3:0]       sel = '0;
  logic [9:0]       lens [4] = '{10'd1023, 10'd64, 10'd128, 10'd64};
  wire  [31:0]      dat_o;
  wire  [9:0]       len;
  wire              ack, lclk, cdet, rsen, ifc, cclk, pwr, wdd, tmo, irq;
  int               fail_count = 0, n_checks = 0, edges, fires, fired_at;

  link_local_ctrl #(.REVISION(REV)) uut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat),
    .dat_o(dat_o), .ack_o(ack), .link_clk_i(lclk), .cable_detect_pin_i(cdet),
    .remote_power_sense_pin_i(rsen), .link_cycle_active_i(act), .interface_clk_en_o(ifc),
    .cable_clock_on_o(cclk), .remote_power_on_o(pwr), .watchdog_disable_o(wdd),
    .timeout_len_o(len), .timeout_o(tmo), .irq_o(irq));
  remote_cam_model cam (.plugged_i(plug), .run_i(act), .cable_clock_on_i(cclk),
    .remote_power_on_i(pwr), .link_clk_o(lclk), .cable_detect_pin_o(cdet),
    .remote_power_sense_pin_o(rsen));

  initial forever #25 clk_i = ~clk_i;
  always @(posedge lclk) if (act) edges++;
  always @(negedge clk_i) if (tmo === 1'b1) begin
    fired_at = edges;
    fires++;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  task automatic bus(input logic w, input logic [13:0] idx, input logic [31:0] d);
    int n = 0;
    @(posedge clk_i);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= d;
    sel <= 4'hF;
    // ack and read data are taken at the rising edge itself, then released
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 20);
    rd = dat_o;
    if (n >= 20) check("ack", 1, 0);
    cyc <= 0;
    stb <= 0;
  endtask : bus

  // link cycle held active for a number of link clock periods
  task automatic frame(input int periods);
    edges = 0;
    fires = 0;
    @(posedge clk_i);
    act <= 1;
    repeat (periods * 8) @(posedge clk_i);
    act <= 0;
    repeat (4) @(posedge clk_i);
  endtask : frame

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // generous bound over the ~1400 cycles the tests need
  initial begin
    #400000;
    fail_count++;
    print_verdict;
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 0;
    repeat (4) @(posedge clk_i);
    bus(0, LOCAL_CTRL_IDX[13:0], 0);
    check("ctrl_rst", {16'h0, 4'h0, REV, 8'h00}, rd);
    check("ports_rst", {1'b1, 3'h0, 10'd1023}, {ifc, cclk, pwr, wdd, len});
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      bus(1, LOCAL_CTRL_IDX[13:0], {16'h0, i[1:0], 14'h3FFF});
      repeat (4) @(posedge clk_i);
      bus(0, LOCAL_CTRL_IDX[13:0], 0);
      check("ctrl_rd", {16'h0, i[1:0], 2'b00, REV, 8'h2F}, rd);
      check("len", lens[i], len);
    end
    check("ports_set", 4'h7, {ifc, cclk, pwr, wdd});
    plug <= 0;
    repeat (4) @(posedge clk_i);
    bus(0, LOCAL_CTRL_IDX[13:0], 0);
    check("unplugged", {16'h0, 4'hC, REV, 8'h8F}, rd);
    plug <= 1;
    $display("test fields done");
    bus(1, LOCAL_UPPER_IDX[13:0], 32'hFFFF);
    bus(0, LOCAL_UPPER_IDX[13:0], 0);
    check("reserved", 0, rd);
    bus(0, 14'h1100, 0);
    check("unmapped", 0, rd);
    $display("test reserved done");
    bus(1, LOCAL_CTRL_IDX[13:0], 32'h4006);
    bus(1, EVT_CLEAR_IDX[13:0], 7);
    bus(1, EVT_ENABLE_IDX[13:0], 1);
    frame(80);
    check("expiry_edge", 65, fired_at);
    check("expiry_count", 1, fires);
    check("irq_set", 1, irq);
    bus(0, EVT_STATUS_IDX[13:0], 0);
    check("status", 1, rd[0]);
    bus(1, EVT_ENABLE_IDX[13:0], 0);
    repeat (2) @(negedge clk_i);
    check("irq_masked", 0, irq);
    bus(1, EVT_ENABLE_IDX[13:0], 1);
    bus(1, EVT_CLEAR_IDX[13:0], 1);
    repeat (2) @(negedge clk_i);
    check("irq_clear", 0, irq);
    bus(1, LOCAL_CTRL_IDX[13:0], 32'h4007);
    frame(80);
    check("wdog_off", 0, fires);
    $display("test watchdog done");
    print_verdict;
  end
endmodule : camera_link_local_control_status_tb
